// [src/mbx_pkg.sv]
// Constants and types shared by the memory map and flash cache block.
// Assumes a 24-bit processor byte address and 32-bit fetch words.
package mbx_pkg;

    // ****************************************
    // Address space
    // ****************************************
    localparam int ADDR_W = 24;                 // 16 MB space
    localparam int REGION_LSB = 20;             // 1 MB regions
    localparam int REGION_W = 4;                // Sixteen regions
    localparam int OFF_W = 20;                  // Offset inside a region
    localparam logic [3:0] REG_INSTR = 4'h0;    // Instruction area
    localparam logic [3:0] REG_DATA = 4'h2;     // Data area
    localparam logic [3:0] REG_DIR = 4'h4;      // Cache directory
    localparam logic [3:0] REG_PERIPH = 4'h7;   // Peripheral registers
    localparam int FLASH_BIT = 23;              // Upper 8 MB is the flash window
    localparam int FLASH_AW = 23;               // Flash window byte address

    // ****************************************
    // On-chip memory layout
    // ****************************************
    localparam logic [19:0] ROM_END = 20'h24000;    // 144 KB ROM
    localparam logic [19:0] IFIX_END = 20'h28000;   // Fixed 16 KB instr bank after ROM
    localparam logic [19:0] DFIX_END = 20'h04000;   // Fixed 16 KB data bank
    localparam int BANK_SHIFT = 15;                 // 32 KB banks
    localparam int NBANK = 7;
    localparam int CACHE_BANK = 6;                  // Only the last bank may cache
    localparam int SLOT_W = 5;

    // ****************************************
    // Cache geometry
    // ****************************************
    localparam int WORD_LSB = 2;
    localparam int WORD_W = 4;                  // 16 words per 64-byte line
    localparam int SET_LSB = 6;
    localparam int SET_W = 8;                   // 256 sets of two ways
    localparam int NSET = 256;
    localparam int TAG_LSB = 14;
    localparam int TAG_W = 9;
    localparam int MEM_AW = 12;                 // Set and word
    localparam logic [3:0] LAST_WORD = 4'hF;
    localparam logic [1:0] STRAP_WAIT = 2'h2;   // Edges for the synchroniser to fill
    localparam logic BOOT_FROM_FLASH = 1'b0;    // Pad level meaning flash boot

    // Bank allocation request
    typedef enum logic [1:0] {
        BANK_OFF = 2'h0,
        BANK_INSTR = 2'h1,
        BANK_DATA = 2'h2,
        BANK_CACHE = 2'h3
    } mbx_bank_mode_t;

    // Decoded target of a core access
    typedef enum logic [8:0] {
        TGT_NONE = 9'h001,
        TGT_ROM = 9'h002,
        TGT_IFIX = 9'h004,
        TGT_DFIX = 9'h008,
        TGT_BANK = 9'h010,
        TGT_PERIPH = 9'h020,
        TGT_DIR = 9'h040,
        TGT_FLASH = 9'h080,
        TGT_FAULT = 9'h100
    } mbx_tgt_t;

    // Cache controller states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOOK = 4'h2,
        ST_FILL = 4'h4,
        ST_DONE = 4'h8
    } mbx_state_t;

endpackage

// [src/mbx_mem_if.sv]
// Port of the cache line storage between controller and memory.
// Assumes both ways are read together as one 64-bit word.
`timescale 1ns/1ps
interface mbx_mem_if;
    logic [11:0] addr;      // Set and word index
    logic [1:0] we;         // Write enable per way
    logic [31:0] wdata;     // Word written into the enabled way
    logic [63:0] rdata;     // Way 1 high, way 0 low
    modport ctl (output addr, output we, output wdata, input rdata);
    modport mem (input addr, input we, input wdata, output rdata);
endinterface

// [src/mbx_line_mem.sv]
// Cache line storage held in the last 32 KB RAM bank.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/1ps
module mbx_line_mem
(
    input wire logic i_clk_sys,
    mbx_mem_if.mem mem
);
    import mbx_pkg::*;

    // ****************************************
    // One array per way
    // ****************************************
    genvar w;
    generate
        for (w = 0; w < 2; w++)
        begin : g_way
            logic [31:0] ram [0:(1 << MEM_AW) - 1];   // Way storage
            logic [31:0] rd_q;                        // Registered read word

            // Write when enabled, read every edge
            always_ff @(posedge i_clk_sys)
            begin
                if (mem.we[w])
                begin
                    ram[mem.addr] <= mem.wdata;
                end
                rd_q <= ram[mem.addr];
            end
            assign mem.rdata[32 * w +: 32] = rd_q;
        end
    endgenerate
endmodule

// [src/mbx_mem_map.sv]
// Address decoder, RAM bank allocation and flash window cache.
// Assumes core requests and the flash link run on i_clk_sys.
// The boot pad is asynchronous and is synchronised here.
//
// How it works
// RULE1: 16 MB decoded as sixteen 1 MB regions
// RULE2: separate instruction and data areas, Harvard
// RULE3: ROM fixed at start of instruction area
// RULE4: two fixed 16 KB banks, instr and data
// RULE5: seven 32 KB banks, each powered separately
// RULE6: bank is off, instr or data; last caches
// RULE7: upper 8 MB window maps external flash
// RULE8: cache read-only, two-way, 64-byte lines
// RULE9: flash execution enabled means cache serves fetches
// RULE10: cache bank never mapped while cache enabled
// RULE11: flash boot pad low enables cache automatically
// RULE12: random flash access only with cache off
// RULE13: directory region writes invalidate tag sets
// RULE14: peripheral registers in dedicated region
// RULE15: miss fetches whole line then returns word
// RULE16: per-set LRU bit picks victim way
`timescale 1ns/1ps
module mbx_mem_map
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_boot_source_select_pad,
    input wire logic i_fw_cache_en,
    input wire mbx_pkg::mbx_bank_mode_t i_bank_mode [mbx_pkg::NBANK],
    input wire logic i_req_valid,
    input wire logic i_req_fetch,
    input wire logic i_req_we,
    input wire logic [mbx_pkg::ADDR_W-1:0] i_req_addr,
    output mbx_pkg::mbx_tgt_t o_tgt,
    output logic [mbx_pkg::OFF_W-1:0] o_offset,
    output logic [mbx_pkg::NBANK-1:0] o_bank_hit,
    output logic [mbx_pkg::NBANK-1:0] o_bank_pwr,
    output logic o_execute_from_flash,
    output logic o_flash_random_ok,
    input wire logic i_xf_req,
    input wire logic [mbx_pkg::FLASH_AW-1:0] i_xf_addr,
    output logic o_xf_ready,
    output logic o_xf_valid,
    output logic [31:0] o_xf_rdata,
    output logic o_fl_req,
    output logic [mbx_pkg::FLASH_AW-1:0] o_fl_addr,
    input wire logic i_fl_valid,
    input wire logic [31:0] i_fl_data
);
    import mbx_pkg::*;

    // ****************************************
    // Boot strap and cache enable
    // ****************************************
    logic pad_s1_q, pad_s2_q;           // Pad synchroniser
    logic [1:0] strap_cnt_q, strap_cnt_d;
    logic boot_flash_q, boot_flash_d;   // Captured boot source
    logic cache_en_q, cache_en_d;       // Cache and flash execution on

    // Next strap and enable values
    always_comb
    begin
        strap_cnt_d = strap_cnt_q;
        boot_flash_d = boot_flash_q;
        // RULE11: catch pad once
        if (strap_cnt_q != STRAP_WAIT + 2'h1)
        begin
            strap_cnt_d = strap_cnt_q + 2'h1;
        end
        if (strap_cnt_q == STRAP_WAIT)
        begin
            boot_flash_d = (pad_s2_q == BOOT_FROM_FLASH);
        end
        // RULE9: flash execution enables cache
        cache_en_d = boot_flash_q | i_fw_cache_en;
    end

    // Register strap state
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            pad_s1_q <= 1'b1;
            pad_s2_q <= 1'b1;
            strap_cnt_q <= 2'h0;
            boot_flash_q <= 1'b0;
            cache_en_q <= 1'b0;
        end
        else
        begin
            pad_s1_q <= i_boot_source_select_pad;
            pad_s2_q <= pad_s1_q;
            strap_cnt_q <= strap_cnt_d;
            boot_flash_q <= boot_flash_d;
            cache_en_q <= cache_en_d;
        end
    end

    assign o_execute_from_flash = cache_en_q;
    // RULE12: random access gate
    assign o_flash_random_ok = ~cache_en_q;

    // ****************************************
    // Bank allocation, one per bank
    // ****************************************
    mbx_bank_mode_t eff_mode [NBANK];   // Mode after cache override
    logic [SLOT_W-1:0] rank [NBANK];    // Position inside its area
    logic [NBANK-1:0] pwr_d, pwr_q;

    genvar b;
    generate
        for (b = 0; b < NBANK; b++)
        begin : g_bank
            // RULE6: one state per bank
            always_comb
            begin
                eff_mode[b] = i_bank_mode[b];
                rank[b] = '0;
                if (b == CACHE_BANK && cache_en_q)
                begin
                    // RULE10: cache owns last bank
                    eff_mode[b] = BANK_CACHE;
                end
                else if (i_bank_mode[b] == BANK_CACHE)
                begin
                    eff_mode[b] = BANK_OFF;
                end
                for (int j = 0; j < b; j++)
                begin
                    if (eff_mode[j] == eff_mode[b])
                    begin
                        rank[b] = rank[b] + 5'h01;
                    end
                end
                // RULE5: power only used banks
                pwr_d[b] = (eff_mode[b] != BANK_OFF);
            end
        end
    endgenerate

    // ****************************************
    // Region decode
    // ****************************************
    logic [REGION_W-1:0] region;
    logic [OFF_W-1:0] off;
    logic [OFF_W-1:0] slot_off;
    mbx_tgt_t tgt_d, tgt_q;
    logic [OFF_W-1:0] off_d, off_q;
    logic [NBANK-1:0] hit_d, hit_q;

    // Decode the core address
    always_comb
    begin
        // RULE1: 1 MB regions
        region = i_req_addr[REGION_LSB +: REGION_W];
        off = i_req_addr[OFF_W-1:0];
        slot_off = '0;
        tgt_d = TGT_NONE;
        off_d = off;
        hit_d = '0;
        if (!i_req_valid)
        begin
            tgt_d = TGT_NONE;
        end
        else if (i_req_addr[FLASH_BIT])
        begin
            // RULE7: flash window, fetch only
            tgt_d = i_req_fetch ? TGT_FLASH : TGT_FAULT;
        end
        else if (region == REG_INSTR)
        begin
            // RULE2: instruction area fetch only
            slot_off = off - IFIX_END;
            if (!i_req_fetch)
            begin
                tgt_d = TGT_FAULT;
            end
            else if (off < ROM_END)
            begin
                // RULE3: ROM at area base
                tgt_d = TGT_ROM;
            end
            else if (off < IFIX_END)
            begin
                // RULE4: fixed instr bank
                tgt_d = TGT_IFIX;
            end
            else
            begin
                for (int k = 0; k < NBANK; k++)
                begin
                    hit_d[k] = (eff_mode[k] == BANK_INSTR)
                               && (rank[k] == slot_off[BANK_SHIFT +: SLOT_W]);
                end
                tgt_d = (hit_d != '0) ? TGT_BANK : TGT_FAULT;
            end
        end
        else if (region == REG_DATA)
        begin
            slot_off = off - DFIX_END;
            if (i_req_fetch)
            begin
                tgt_d = TGT_FAULT;
            end
            else if (off < DFIX_END)
            begin
                // RULE4: fixed data bank
                tgt_d = TGT_DFIX;
            end
            else
            begin
                for (int k = 0; k < NBANK; k++)
                begin
                    hit_d[k] = (eff_mode[k] == BANK_DATA)
                               && (rank[k] == slot_off[BANK_SHIFT +: SLOT_W]);
                end
                tgt_d = (hit_d != '0) ? TGT_BANK : TGT_FAULT;
            end
        end
        else if (region == REG_DIR && !i_req_fetch)
        begin
            tgt_d = TGT_DIR;
        end
        else if (region == REG_PERIPH && !i_req_fetch)
        begin
            // RULE14: peripheral register region
            tgt_d = TGT_PERIPH;
        end
        else
        begin
            tgt_d = TGT_FAULT;
        end
    end

    // Register decode results
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            tgt_q <= TGT_NONE;
            off_q <= '0;
            hit_q <= '0;
            pwr_q <= '0;
        end
        else
        begin
            tgt_q <= tgt_d;
            off_q <= off_d;
            hit_q <= hit_d;
            pwr_q <= pwr_d;
        end
    end

    assign o_tgt = tgt_q;
    assign o_offset = off_q;
    assign o_bank_hit = hit_q;
    assign o_bank_pwr = pwr_q;

    // ****************************************
    // Flash window cache
    // ****************************************
    mbx_mem_if mif ();
    mbx_line_mem u_line_mem (.i_clk_sys(i_clk_sys), .mem(mif));

    mbx_state_t st_q, st_d;
    logic [TAG_W-1:0] tag_q [NSET][2], tag_d [NSET][2];
    logic [1:0] vld_q [NSET], vld_d [NSET];
    logic [NSET-1:0] lru_q, lru_d;      // Way to replace next
    logic [FLASH_AW-1:0] ra_q, ra_d;    // Request address
    logic [WORD_W-1:0] cnt_q, cnt_d;    // Fill beat count
    logic vic_q, vic_d;                 // Victim way
    logic xv_q, xv_d;
    logic [31:0] xd_q, xd_d;
    logic [SET_W-1:0] set_r, set_dir;
    logic [TAG_W-1:0] tag_r;
    logic [1:0] hit;
    logic [WORD_W-1:0] beat_q, beat_d; // Fill beats seen by the checks

    assign set_r = ra_q[SET_LSB +: SET_W];
    assign tag_r = ra_q[TAG_LSB +: TAG_W];
    assign set_dir = i_req_addr[SET_LSB +: SET_W];
    assign hit[0] = vld_q[set_r][0] && (tag_q[set_r][0] == tag_r);
    assign hit[1] = vld_q[set_r][1] && (tag_q[set_r][1] == tag_r);
    assign o_xf_ready = (st_q == ST_IDLE) && cache_en_q;
    assign o_fl_req = (st_q == ST_FILL);
    assign o_fl_addr = {ra_q[FLASH_AW-1:SET_LSB], 6'h00};
    assign o_xf_valid = xv_q;
    assign o_xf_rdata = xd_q;

    // Next cache state
    always_comb
    begin
        st_d = st_q;
        tag_d = tag_q;
        vld_d = vld_q;
        lru_d = lru_q;
        ra_d = ra_q;
        cnt_d = cnt_q;
        vic_d = vic_q;
        xv_d = 1'b0;
        xd_d = xd_q;
        beat_d = o_fl_req ? beat_q + 4'(i_fl_valid) : '0;
        mif.addr = {set_r, ra_q[WORD_LSB +: WORD_W]};
        mif.we = 2'h0;
        mif.wdata = i_fl_data;
        // RULE13: directory write invalidates
        if (i_req_valid && i_req_we && tgt_d == TGT_DIR)
        begin
            vld_d[set_dir] = 2'h0;
        end
        unique case (st_q)
            ST_IDLE:
            begin
                mif.addr = {i_xf_addr[SET_LSB +: SET_W], i_xf_addr[WORD_LSB +: WORD_W]};
                // RULE9: serve window fetches
                if (i_xf_req && o_xf_ready)
                begin
                    ra_d = i_xf_addr;
                    st_d = ST_LOOK;
                end
            end
            ST_LOOK:
            begin
                // RULE8: two-way lookup
                if (hit != 2'h0)
                begin
                    xv_d = 1'b1;
                    xd_d = hit[1] ? mif.rdata[63:32] : mif.rdata[31:0];
                    lru_d[set_r] = ~hit[1];
                    st_d = ST_IDLE;
                end
                else
                begin
                    // RULE16: invalid way first, else LRU
                    vic_d = !vld_q[set_r][0] ? 1'b0 : (!vld_q[set_r][1] ? 1'b1 : lru_q[set_r]);
                    cnt_d = '0;
                    st_d = ST_FILL;
                end
            end
            ST_FILL:
            begin
                // RULE15: fill whole line
                mif.addr = {set_r, cnt_q};
                if (i_fl_valid)
                begin
                    mif.we[vic_q] = 1'b1;
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == LAST_WORD)
                    begin
                        tag_d[set_r][vic_q] = tag_r;
                        vld_d[set_r][vic_q] = 1'b1;
                        st_d = ST_DONE;
                    end
                end
            end
            ST_DONE:
            begin
                // Reread the requested word, then hit
                st_d = ST_LOOK;
            end
        endcase
    end

    // Register cache state
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_q <= ST_IDLE;
            tag_q <= '{default: '0};
            vld_q <= '{default: 2'h0};
            lru_q <= '0;
            ra_q <= '0;
            cnt_q <= '0;
            vic_q <= 1'b0;
            xv_q <= 1'b0;
            xd_q <= '0;
            beat_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            tag_q <= tag_d;
            vld_q <= vld_d;
            lru_q <= lru_d;
            ra_q <= ra_d;
            cnt_q <= cnt_d;
            vic_q <= vic_d;
            xv_q <= xv_d;
            xd_q <= xd_d;
            beat_q <= beat_d;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    cache_bank_a: assert property (cache_en_q && $past(cache_en_q) // RULE10
        |-> !hit_q[CACHE_BANK])
        else $error("cache bank decoded while cache on");
    random_gate_a: assert property (o_flash_random_ok != o_execute_from_flash) // RULE12
        else $error("random flash gate wrong");
    harvard_a: assert property (i_req_valid && i_req_fetch && i_req_addr[23:20] == REG_DATA
        |=> o_tgt == TGT_FAULT) // RULE2
        else $error("fetch from data area not refused");
    rom_dec_a: assert property (i_req_valid && i_req_fetch && i_req_addr[23:20] == REG_INSTR
        && i_req_addr[19:0] < ROM_END |=> o_tgt == TGT_ROM) // RULE3
        else $error("rom not decoded");
    fill_len_a: assert property (o_fl_req && !(i_fl_valid && beat_q == LAST_WORD) // RULE15
        |=> o_fl_req)
        else $error("fill shorter than a line");
    miss_resp_a: assert property (o_fl_req && i_fl_valid && beat_q == LAST_WORD // RULE15
        |=> !o_fl_req ##2 o_xf_valid)
        else $error("no answer after fill");
    hit_resp_a: assert property (o_xf_ready && i_xf_req ##1 hit != 2'h0 |=> o_xf_valid) // RULE8
        else $error("hit not answered");
    pwr_off_a: assert property (i_bank_mode[0] == BANK_OFF |=> !o_bank_pwr[0]) // RULE5
        else $error("unused bank powered");
    strap_a: assert property (strap_cnt_q == STRAP_WAIT && pad_s2_q == BOOT_FROM_FLASH // RULE11
        |=> ##1 o_execute_from_flash)
        else $error("flash boot did not enable cache");
endmodule

// [testbench/mbx_flash_model.sv]
// Flash line source that answers the cache's line fills.
// Assumes one clock; beats are offered only while a fill is requested.
`timescale 1ns/1ps
module mbx_flash_model
(
    input wire logic i_clk_sys,
    input wire logic i_slow,
    input wire logic i_fl_req,
    input wire logic [22:0] i_fl_addr,
    output logic o_fl_valid,
    output logic [31:0] o_fl_data
);
    // ****
    // Beat source
    // ****
    int cnt; // Beats already taken
    logic [7:0] lf; // Gap pattern for slow mode
    logic [22:0] wa; // Byte address of the next beat
    initial
    begin
        cnt = 0;
        lf = 8'h5B;
        o_fl_valid = 1'b0;
        o_fl_data = 32'h0;
    end
    always @(posedge i_clk_sys)
    begin
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        if (o_fl_valid && i_fl_req)
            cnt = cnt + 1;
        if (!i_fl_req)
            cnt = 0;
        wa = {i_fl_addr[22:6], 6'(cnt * 4)};
        // Slow mode leaves random gaps
        if (i_fl_req && cnt < 16 && !(i_slow && lf[0]))
        begin
            o_fl_valid <= 1'b1;
            o_fl_data <= {~wa[8:0], wa};
        end
        else
        begin
            // Released data line toggles, never holds the last word
            o_fl_valid <= 1'b0;
            o_fl_data <= ~o_fl_data;
        end
    end
endmodule

// [testbench/test_memory_bank_map_and_xip_cache.sv]
// Self-checking bench for the memory map and flash cache.
// Assumes the flash model above answers the line fills.
`timescale 1ns/1ps
module test_memory_bank_map_and_xip_cache;
    import mbx_pkg::*;
    // ****
    // Signals
    // ****
    logic clk = 1'b0, rst = 1'b1, pad = 1'b1, fwen = 1'b0, slow = 1'b0;
    logic rv = 1'b0, rf = 1'b0, rw = 1'b0, xreq = 1'b0, cen = 1'b0;
    logic [23:0] ra = 24'h0;
    logic [22:0] xa = 23'h0, fla;
    mbx_bank_mode_t mode [NBANK];
    mbx_tgt_t tgt;
    logic [19:0] off;
    logic [6:0] hit, pwr;
    logic xff, rok, xrdy, xval, flreq, flval;
    logic [31:0] xrd, fld, seed = 32'd59047;
    int miscompares = 0, checked = 0;
    mbx_mem_map u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_boot_source_select_pad(pad),
        .i_fw_cache_en(fwen), .i_bank_mode(mode), .i_req_valid(rv), .i_req_fetch(rf),
        .i_req_we(rw), .i_req_addr(ra), .o_tgt(tgt), .o_offset(off), .o_bank_hit(hit),
        .o_bank_pwr(pwr), .o_execute_from_flash(xff), .o_flash_random_ok(rok),
        .i_xf_req(xreq), .i_xf_addr(xa), .o_xf_ready(xrdy), .o_xf_valid(xval),
        .o_xf_rdata(xrd), .o_fl_req(flreq), .o_fl_addr(fla), .i_fl_valid(flval),
        .i_fl_data(fld));
    mbx_flash_model u_fl (.i_clk_sys(clk), .i_slow(slow), .i_fl_req(flreq),
        .i_fl_addr(fla), .o_fl_valid(flval), .o_fl_data(fld));
    always #20 clk = ~clk;
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] fw(input logic [22:0] a);
        return {~a[8:0], a};
    endfunction
    // Effective bank mode, cache bank taken over when enabled
    function automatic mbx_bank_mode_t eff(input int i);
        if (i == CACHE_BANK && cen)
            return BANK_CACHE;
        return (mode[i] == BANK_CACHE) ? BANK_OFF : mode[i];
    endfunction
    // Expected decode of one core access
    function automatic void ref_dec(input logic v, f, input logic [23:0] a,
        output mbx_tgt_t t, output logic [6:0] h);
        logic [19:0] o;
        int s, k;
        mbx_bank_mode_t w;
        o = a[19:0];
        t = TGT_FAULT;
        h = 7'h00;
        s = -1;
        w = BANK_OFF;
        k = 0;
        if (!v)
            t = TGT_NONE;
        else if (a[FLASH_BIT])
            t = f ? TGT_FLASH : TGT_FAULT;
        else if (a[23:20] == REG_INSTR && f)
        begin
            t = (o < ROM_END) ? TGT_ROM : (o < IFIX_END) ? TGT_IFIX : TGT_FAULT;
            s = (o < IFIX_END) ? -1 : int'((o - IFIX_END) >> BANK_SHIFT);
            w = BANK_INSTR;
        end
        else if (a[23:20] == REG_DATA && !f)
        begin
            t = (o < DFIX_END) ? TGT_DFIX : TGT_FAULT;
            s = (o < DFIX_END) ? -1 : int'((o - DFIX_END) >> BANK_SHIFT);
            w = BANK_DATA;
        end
        else if (a[23:20] == REG_DIR || a[23:20] == REG_PERIPH)
            t = f ? TGT_FAULT : (a[23:20] == REG_DIR) ? TGT_DIR : TGT_PERIPH;
        // Banks stack in index order
        for (int i = 0; i < NBANK; i++)
        begin
            if (s >= 0 && eff(i) == w)
            begin
                if (k == s)
                begin
                    t = TGT_BANK;
                    h[i] = 1'b1;
                end
                k++;
            end
        end
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // New random bank modes, then let power settle
    task automatic set_modes();
        logic [31:0] r;
        r = xs();
        @(posedge clk);
        for (int i = 0; i < NBANK; i++)
            mode[i] <= (i == CACHE_BANK && r[2*i+:2] == 2'h3) ? BANK_DATA
                : mbx_bank_mode_t'(r[2*i+:2]);
        repeat (2) @(posedge clk);
    endtask
    // Back to back decode requests, each checked one cycle later
    task automatic dec_run(input int n);
        logic [31:0] r;
        logic pv, pf, nf;
        logic [23:0] pa, na;
        logic [19:0] c [8] = '{20'h23FFC, 20'h24000, 20'h27FFC, 20'h28000,
            20'h03FFC, 20'h04000, 20'h2FFFC, 20'h0C000};
        mbx_tgt_t et;
        logic [6:0] eh, ep;
        pv = 1'b0;
        pf = 1'b0;
        pa = 24'h0;
        for (int i = 0; i <= n; i++)
        begin
            r = xs();
            na = {r[23:20], r[19] ? c[r[2:0]] : {1'b0, r[18:2], 2'b00}};
            nf = r[28] && (!na[23] || cen);
            @(posedge clk);
            rv <= (i < n) && r[31:29] != 3'h0;
            rf <= nf;
            rw <= r[27] && !nf;
            ra <= na;
            @(negedge clk);
            ref_dec(pv, pf, pa, et, eh);
            for (int b = 0; b < NBANK; b++)
                ep[b] = eff(b) != BANK_OFF;
            if (i > 0)
            begin
                chk("tgt", 32'(et), 32'(tgt));
                chk("bank_hit", 32'(eh), 32'(hit));
                chk("bank_pwr", 32'(ep), 32'(pwr));
                if (pv)
                    chk("offset", 32'(pa[19:0]), 32'(off));
            end
            pv = (i < n) && r[31:29] != 3'h0;
            pf = nf;
            pa = na;
        end
    endtask
    // One fetch through the cache; kind 0 hit, 1 miss, 2 either
    task automatic xfetch(input logic [22:0] a, input int kind);
        int n;
        logic sf;
        logic [22:0] ba;
        n = 0;
        sf = 1'b0;
        ba = 23'h0;
        while (xrdy !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        xreq <= 1'b1;
        xa <= a;
        @(posedge clk);
        xreq <= 1'b0;
        n = 0;
        while (n < 300 && xval !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (flreq === 1'b1)
            begin
                sf = 1'b1;
                ba = fla;
            end
        end
        chk("xf_valid", 32'h1, 32'(xval));
        chk("xf_rdata", fw(a), xrd);
        if (sf)
            chk("fl_addr", {9'h0, a[22:6], 6'h0}, 32'(ba));
        if (kind < 2)
            chk("hit_miss", kind ? 32'h1 : 32'h2, sf ? 32'h1 : 32'(n));
    endtask
    // ****
    // Main sequence
    // ****
    initial
    begin
        for (int i = 0; i < NBANK; i++)
            mode[i] = BANK_OFF;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("exec_flash", 32'h0, 32'(xff));
        chk("random_ok", 32'h1, 32'(rok));
        repeat (3)
        begin
            set_modes();
            dec_run(300);
        end
        @(posedge clk);
        fwen <= 1'b1;
        cen = 1'b1;
        repeat (3)
        begin
            set_modes();
            chk("exec_flash", 32'h1, 32'(xff));
            chk("random_ok", 32'h0, 32'(rok));
            dec_run(300);
        end
        xfetch(23'h000044, 1);
        xfetch(23'h000048, 0);
        slow <= 1'b1;
        xfetch(23'h00407C, 1);
        xfetch(23'h000040, 0);
        xfetch(23'h008040, 1);
        xfetch(23'h00004C, 0);
        xfetch(23'h004040, 1);
        // Directory write to set 1 drops both ways
        @(posedge clk);
        rv <= 1'b1;
        rw <= 1'b1;
        rf <= 1'b0;
        ra <= 24'h400040;
        @(posedge clk);
        rv <= 1'b0;
        rw <= 1'b0;
        xfetch(23'h000040, 1);
        xfetch(23'h004040, 1);
        for (int i = 0; i < 40; i++)
        begin
            slow <= seed[3];
            xfetch(23'(xs()) & 23'h7FFFFC, 2);
        end
        // Flash boot strap enables the cache without firmware
        @(posedge clk);
        rst <= 1'b1;
        pad <= 1'b0;
        fwen <= 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(negedge clk);
        chk("exec_flash", 32'h1, 32'(xff));
        chk("xf_ready", 32'h1, 32'(xrdy));
        xfetch(23'h000040, 1);
        end_of_test();
    end
    // Watchdog against a hung handshake
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
endmodule
